// File: rtl/rtc_pkg.sv
// constants, offsets and reset values shared by the clock block
package rtc_pkg;

  // bus clock and the length of one timekeeping second
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_NS     = 1_000_000_000;
  localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CTRL       = 8'h60;
  localparam logic [7:0] IDX_SEC        = 8'h61;
  localparam logic [7:0] IDX_MIN_LOW    = 8'h62;
  localparam logic [7:0] IDX_MIN_MID    = 8'h63;
  localparam logic [7:0] IDX_MIN_HIGH   = 8'h64;
  localparam logic [7:0] IDX_ASEC       = 8'h65;
  localparam logic [7:0] IDX_AMIN_LOW   = 8'h66;
  localparam logic [7:0] IDX_AMIN_MID   = 8'h67;
  localparam logic [7:0] IDX_AMIN_HIGH  = 8'h68;
  localparam logic [7:0] IDX_SCRATCH    = 8'h69;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h6a;

  // control register fields
  localparam int unsigned CTRL_MODE_LSB = 3;
  localparam int unsigned CTRL_OSC_BIT  = 2;
  localparam int unsigned CTRL_AWAKE    = 1;
  localparam int unsigned CTRL_PWAKE    = 0;

  // interrupt mask fields
  localparam int unsigned MASK_ALARM    = 0;
  localparam int unsigned MASK_PER      = 1;

  // reset values
  localparam logic [4:0]  CTRL_RST      = 5'h00;
  localparam logic [7:0]  SEC_RST       = 8'h00;
  localparam logic [23:0] MIN_RST       = 24'h00_0000;
  localparam logic [7:0]  ASEC_RST      = 8'h3f;
  localparam logic [7:0]  AMIN_BYTE_RST = 8'hff;
  localparam logic [23:0] AMIN_RST      = 24'hff_ffff;
  localparam logic [7:0]  SCRATCH_RST   = 8'h00;
  localparam logic [1:0]  MASK_RST      = 2'h3;

  // timekeeping figures
  localparam logic [7:0]  SEC_LAST      = 8'h3b;
  localparam logic [2:0]  MIN8_ZERO     = 3'h0;

  // periodic interval codes, in documented order
  typedef enum logic [1:0] {
    PER_SECOND,
    PER_MINUTE,
    PER_TWO_MIN,
    PER_EIGHT_MIN
  } period_mode_e;

endpackage

// File: rtl/sec_tick_gen.sv
// one-second tick prescaler running while the oscillator is on
`timescale 1ns/1ps
`default_nettype none
module sec_tick_gen #(
  parameter int unsigned CYCLES = rtc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // control and tick
  input  wire logic enable,
  output var  logic tick
);

  // refuse a count the counter cannot serve
  if (CYCLES < 2) begin : g_bad_cycles
    $error("sec_tick_gen: CYCLES must be at least 2");
  end

  localparam int unsigned CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_reg; // cycles into the current second

  // count while enabled; stopping restarts the second from zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (!enable) begin
      count_reg <= '0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // tick is a one-cycle pulse at the end of each second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= enable && (count_reg == LAST);
    end
  end

endmodule // sec_tick_gen
`default_nettype wire

// File: rtl/rtc_alarm_periodic_wake.sv
// real-time clock with alarm, periodic event and wake requests
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_periodic_wake #(
  parameter int unsigned TICK_CYCLES = rtc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // oscillator and events
  output var  logic        osc_enable,
  output var  logic        alarm_event,
  output var  logic        periodic_event,
  output var  logic        wake_request,
  output var  logic        rtc_irq
);

  // refuse a prescale the tick generator cannot serve
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("rtc: TICK_CYCLES must be at least 2");
  end

  // ---- register state ----
  logic [4:0]  ctrl_reg;      // interval, osc, wake enables
  logic [7:0]  sec_reg;       // running seconds
  logic [23:0] min_reg;       // running minutes
  logic [7:0]  asec_reg;      // alarm seconds shadow
  logic [7:0]  amin_low_reg;  // alarm minute low shadow
  logic [7:0]  amin_mid_reg;  // alarm minute mid shadow
  logic [7:0]  amin_high_reg; // alarm minute high shadow
  logic [7:0]  act_sec_reg;   // active alarm seconds
  logic [23:0] act_min_reg;   // active alarm minutes
  logic [7:0]  scratch_reg;   // spare byte
  logic [1:0]  mask_reg;      // event masks, one blocks
  logic        match_reg;     // previous cycle compare result

  // ---- bus decode ----
  logic        acc_fire;  // request taken this edge
  logic        wr_fire;   // write lands on lane 0 this edge
  logic [7:0]  wdata;     // write byte
  logic [7:0]  widx;      // register index of the access
  logic        aligned;   // address is word aligned
  logic [7:0]  rd_byte;   // read mux output
  logic        rd_hit;    // read address is mapped

  // ---- timekeeping ----
  logic        tick;      // one-second pulse
  logic        time_wr;   // software writes a time byte
  logic        tick_eff;  // tick that really advances time
  logic        sec_wrap;  // seconds roll over this tick
  logic [23:0] min_inc;   // minutes plus one
  logic        per_next;  // periodic event next cycle
  logic        alarm_next;// alarm event next cycle
  logic        match_now; // count equals active alarm
  rtc_pkg::period_mode_e mode; // selected interval

  assign widx    = avs_address[9:2];
  assign aligned = (avs_address[1:0] == 2'b00);
  assign wdata   = avs_writedata[7:0];

  // an access is answered on the second edge of its request
  assign acc_fire = (avs_read || avs_write) && !avs_waitrequest;
  // only lane 0 carries data; other lanes are ignored
  assign wr_fire  = acc_fire && avs_write && avs_byteenable[0]
                    && aligned;

  // waitrequest stands high when idle and drops for one cycle
  // a cycle after the request rises, so every access takes two
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_waitrequest) begin
      avs_waitrequest <= !(avs_read || avs_write);
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read data is loaded as waitrequest drops and holds until the next read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // read mux; unmapped or unaligned addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = aligned;
    if (widx == rtc_pkg::IDX_CTRL) begin
      rd_byte = {3'b000, ctrl_reg};
    end else if (widx == rtc_pkg::IDX_SEC) begin
      rd_byte = sec_reg;
    end else if (widx == rtc_pkg::IDX_MIN_LOW) begin
      rd_byte = min_reg[7:0];
    end else if (widx == rtc_pkg::IDX_MIN_MID) begin
      rd_byte = min_reg[15:8];
    end else if (widx == rtc_pkg::IDX_MIN_HIGH) begin
      rd_byte = min_reg[23:16];
    end else if (widx == rtc_pkg::IDX_ASEC) begin
      rd_byte = asec_reg;
    end else if (widx == rtc_pkg::IDX_AMIN_LOW) begin
      rd_byte = amin_low_reg;
    end else if (widx == rtc_pkg::IDX_AMIN_MID) begin
      rd_byte = amin_mid_reg;
    end else if (widx == rtc_pkg::IDX_AMIN_HIGH) begin
      rd_byte = amin_high_reg;
    end else if (widx == rtc_pkg::IDX_SCRATCH) begin
      rd_byte = scratch_reg;
    end else if (widx == rtc_pkg::IDX_IRQ_MASK) begin
      rd_byte = {6'h00, mask_reg};
    end else begin
      rd_hit = 1'b0;
    end
    if (!rd_hit) begin
      rd_byte = 8'h00;
    end
  end

  // control register: interval, oscillator, wake enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= rtc_pkg::CTRL_RST;
    end else if (wr_fire && widx == rtc_pkg::IDX_CTRL) begin
      ctrl_reg <= wdata[4:0];
    end
  end

  // interrupt masks, both blocked out of reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= rtc_pkg::MASK_RST;
    end else if (wr_fire && widx == rtc_pkg::IDX_IRQ_MASK) begin
      mask_reg <= wdata[1:0];
    end
  end

  // scratch byte; touches nothing else
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scratch_reg <= rtc_pkg::SCRATCH_RST;
    end else if (wr_fire && widx == rtc_pkg::IDX_SCRATCH) begin
      scratch_reg <= wdata;
    end
  end

  // oscillator enable pin follows its control bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= ctrl_reg[rtc_pkg::CTRL_OSC_BIT];
    end
  end

  // seconds prescaler; stopped while the oscillator is off
  sec_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .enable  (ctrl_reg[rtc_pkg::CTRL_OSC_BIT]),
    .tick    (tick)
  );

  // a software write to the time wins; that tick is dropped
  // rather than corrupting the freshly written value
  assign time_wr = wr_fire && (widx == rtc_pkg::IDX_SEC
                   || widx == rtc_pkg::IDX_MIN_LOW
                   || widx == rtc_pkg::IDX_MIN_MID
                   || widx == rtc_pkg::IDX_MIN_HIGH);
  assign tick_eff = tick && !time_wr;

  // wrap at 59; a value written above 59 also wraps next tick
  assign sec_wrap = (sec_reg >= rtc_pkg::SEC_LAST);
  assign min_inc  = min_reg + 24'h00_0001;

  // seconds counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sec_reg <= rtc_pkg::SEC_RST;
    end else if (wr_fire && widx == rtc_pkg::IDX_SEC) begin
      sec_reg <= wdata;
    end else if (tick_eff) begin
      if (sec_wrap) begin
        sec_reg <= rtc_pkg::SEC_RST;
      end else begin
        sec_reg <= sec_reg + 8'h01;
      end
    end
  end

  // minute counter, three byte lanes written separately
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      min_reg <= rtc_pkg::MIN_RST;
    end else if (wr_fire && widx == rtc_pkg::IDX_MIN_LOW) begin
      min_reg[7:0] <= wdata;
    end else if (wr_fire && widx == rtc_pkg::IDX_MIN_MID) begin
      min_reg[15:8] <= wdata;
    end else if (wr_fire && widx == rtc_pkg::IDX_MIN_HIGH) begin
      min_reg[23:16] <= wdata;
    end else if (tick_eff && sec_wrap) begin
      min_reg <= min_inc;
    end
  end

  // alarm shadow bytes; readable, not yet compared
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      asec_reg      <= rtc_pkg::ASEC_RST;
      amin_low_reg  <= rtc_pkg::AMIN_BYTE_RST;
      amin_mid_reg  <= rtc_pkg::AMIN_BYTE_RST;
      amin_high_reg <= rtc_pkg::AMIN_BYTE_RST;
    end else if (wr_fire) begin
      if (widx == rtc_pkg::IDX_ASEC) begin
        asec_reg <= wdata;
      end else if (widx == rtc_pkg::IDX_AMIN_LOW) begin
        amin_low_reg <= wdata;
      end else if (widx == rtc_pkg::IDX_AMIN_MID) begin
        amin_mid_reg <= wdata;
      end else if (widx == rtc_pkg::IDX_AMIN_HIGH) begin
        amin_high_reg <= wdata;
      end
    end
  end

  // the active alarm moves as one word on the top byte write,
  // so the compare never sees a half-updated alarm
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_sec_reg <= rtc_pkg::ASEC_RST;
      act_min_reg <= rtc_pkg::AMIN_RST;
    end else if (wr_fire && widx == rtc_pkg::IDX_AMIN_HIGH) begin
      act_sec_reg <= asec_reg;
      act_min_reg <= {wdata, amin_mid_reg, amin_low_reg};
    end
  end

  // compare running time with the active alarm
  assign match_now = (sec_reg == act_sec_reg)
                     && (min_reg == act_min_reg);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= match_now;
    end
  end

  // alarm fires once, in the first cycle of a match, only while
  // the oscillator runs; a stopped clock raises no alarm
  assign alarm_next = ctrl_reg[rtc_pkg::CTRL_OSC_BIT]
                      && match_now && !match_reg;

  // periodic interval selection
  assign mode = rtc_pkg::period_mode_e'(
                ctrl_reg[rtc_pkg::CTRL_MODE_LSB +: 2]);

  always_comb begin
    per_next = 1'b0;
    case (mode)
      rtc_pkg::PER_SECOND: begin
        per_next = tick_eff;
      end
      rtc_pkg::PER_MINUTE: begin
        per_next = tick_eff && sec_wrap;
      end
      rtc_pkg::PER_TWO_MIN: begin
        per_next = tick_eff && sec_wrap
                   && !min_inc[0];
      end
      rtc_pkg::PER_EIGHT_MIN: begin
        per_next = tick_eff && sec_wrap
                   && (min_inc[2:0] == rtc_pkg::MIN8_ZERO);
      end
      default: begin
        per_next = 1'b0;
      end
    endcase
  end

  // event pulses, one cycle each
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alarm_event    <= 1'b0;
      periodic_event <= 1'b0;
    end else begin
      alarm_event    <= alarm_next;
      periodic_event <= per_next;
    end
  end

  // wake from power-off, each source behind its own enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <=
        (alarm_next && ctrl_reg[rtc_pkg::CTRL_AWAKE])
        || (per_next && ctrl_reg[rtc_pkg::CTRL_PWAKE]);
    end
  end

  // interrupt pulse; a set mask bit blocks its event
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rtc_irq <= 1'b0;
    end else begin
      rtc_irq <=
        (alarm_next && !mask_reg[rtc_pkg::MASK_ALARM])
        || (per_next && !mask_reg[rtc_pkg::MASK_PER]);
    end
  end

endmodule // rtc_alarm_periodic_wake
`default_nettype wire

// File: verif/rtc_alarm_periodic_wake_chk.sv
// port-level checker for the clock block, bound into the design
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_periodic_wake_chk #(
  parameter int unsigned TICK_CYCLES = 16
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // avalon-mm slave
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // oscillator and events
  input wire logic        osc_enable,
  input wire logic        alarm_event,
  input wire logic        periodic_event,
  input wire logic        wake_request,
  input wire logic        rtc_irq
);
  logic        wr_ok;    // write accepted in this cycle
  logic [4:0]  ctrl_reg; // mirror of the control byte
  logic [1:0]  mask_reg; // mirror of the mask bits
  logic [3:0]  off_reg;  // cycles with the oscillator off, saturating
  logic [31:0] gap_reg;  // cycles since the last periodic event
  logic        seen_reg; // an earlier event with no write since
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0]
                 && (avs_address[1:0] == 2'h0);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // mirrors follow accepted writes at the edge the design updates
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 5'h00;
      mask_reg <= 2'h3;
    end else if (wr_ok) begin
      if (avs_address[9:2] == rtc_pkg::IDX_CTRL) begin
        ctrl_reg <= avs_writedata[4:0];
      end
      if (avs_address[9:2] == rtc_pkg::IDX_IRQ_MASK) begin
        mask_reg <= avs_writedata[1:0];
      end
    end
  end
  // any aligned lane-0 write clears seen_reg: a dropped tick must not look like a slip
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      off_reg  <= 4'h0;
      gap_reg  <= 32'h0000_0000;
      seen_reg <= 1'b0;
    end else begin
      if (ctrl_reg[2]) begin
        off_reg <= 4'h0;
      end else if (off_reg != 4'hf) begin
        off_reg <= off_reg + 4'h1;
      end
      gap_reg  <= periodic_event ? 32'h0000_0001 : gap_reg + 32'h0000_0001;
      seen_reg <= wr_ok ? 1'b0 : (periodic_event ? 1'b1 : seen_reg);
    end
  end
  wait_one_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after a request");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  ack_cause_a: assert property (
    !avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  data_high_a: assert property (avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  osc_copy_a: assert property (osc_enable == $past(ctrl_reg[2]))
    else $error("oscillator enable does not follow control bit");
  // enables and masks act on the pulse one cycle before it shows
  wake_mix_a: assert property (
    wake_request == ((alarm_event && $past(ctrl_reg[1])) ||
                     (periodic_event && $past(ctrl_reg[0]))))
    else $error("wake request not gated by its enables");
  irq_mix_a: assert property (
    rtc_irq == ((alarm_event && !$past(mask_reg[0])) ||
                (periodic_event && !$past(mask_reg[1]))))
    else $error("interrupt not gated by its masks");
  osc_off_a: assert property (
    off_reg >= 4'h4 |-> !alarm_event && !periodic_event)
    else $error("event with the oscillator off");
  gap_sec_a: assert property (
    periodic_event && seen_reg && ctrl_reg[4:3] == 2'h0 |->
      gap_reg == TICK_CYCLES)
    else $error("per-second event spacing wrong");
  alarm_once_a: assert property (alarm_event |=> !alarm_event)
    else $error("alarm event longer than one cycle");
  // main scenarios reached
  per_wake_c: cover property (periodic_event && wake_request);
  alarm_irq_c: cover property (alarm_event && rtc_irq);
  read_done_c: cover property (avs_read && !avs_waitrequest);
endmodule // rtc_alarm_periodic_wake_chk
bind rtc_alarm_periodic_wake rtc_alarm_periodic_wake_chk #(
  .TICK_CYCLES(TICK_CYCLES)
) chk (
  .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .osc_enable,
  .alarm_event, .periodic_event, .wake_request, .rtc_irq
);
`default_nettype wire

// File: verif/tb_rtc_alarm_periodic_wake.sv
// self-checking bench for the clock block
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_alarm_periodic_wake;
  localparam int unsigned TICK = 16; // shortened second keeps the run small
  logic        clk_sys;         // bus clock
  logic        rst_n;           // active low reset
  logic [9:0]  avs_address;     // byte address
  logic        avs_read;        // read strobe
  logic        avs_write;       // write strobe
  logic [31:0] avs_writedata;   // write data
  logic [3:0]  avs_byteenable;  // lane enables
  logic [31:0] avs_readdata;    // read data
  logic        avs_waitrequest; // slave stall
  logic        osc_enable;      // oscillator on
  logic        alarm_event;     // alarm pulse
  logic        periodic_event;  // interval pulse
  logic        wake_request;    // wake pulse
  logic        rtc_irq;         // interrupt pulse
  logic [31:0] rd;              // last read data
  int          fail_count;      // mismatches
  int          tests_run;       // comparisons
  int          cycles;          // watchdog count
  int          pc, ac, wc, ic;  // event tallies of one window
  rtc_alarm_periodic_wake #(.TICK_CYCLES(TICK)) dut (
    .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .osc_enable,
    .alarm_event, .periodic_event, .wake_request, .rtc_irq
  );
  // 100 MHz clock
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  // verdict and end of run
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // cuts a hang short well past the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      close_out;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] data, input logic be0);
    avs_address    <= {idx, 2'h0};
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {24'h00_0000, data};
    avs_byteenable <= {3'h0, be0};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask
  // loads seconds and the three minute bytes, oscillator off
  task automatic set_time(input logic [7:0] s, input logic [23:0] m);
    bus(1'b1, rtc_pkg::IDX_SEC, s, 1'b1);
    bus(1'b1, rtc_pkg::IDX_MIN_LOW, m[7:0], 1'b1);
    bus(1'b1, rtc_pkg::IDX_MIN_MID, m[15:8], 1'b1);
    bus(1'b1, rtc_pkg::IDX_MIN_HIGH, m[23:16], 1'b1);
  endtask
  // tallies each event output once per cycle
  task automatic count(input int len);
    pc = 0; ac = 0; wc = 0; ic = 0;
    repeat (len) begin
      @(posedge clk_sys);
      pc += int'(periodic_event === 1'b1);
      ac += int'(alarm_event === 1'b1);
      wc += int'(wake_request === 1'b1);
      ic += int'(rtc_irq === 1'b1);
    end
  endtask
  function automatic logic [31:0] tally();
    return {pc[7:0], ac[7:0], wc[7:0], ic[7:0]};
  endfunction
  task automatic t_reset;
    logic [7:0] exp [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f,
                             8'hff, 8'hff, 8'hff, 8'h00, 8'h03};
    check({31'h0, osc_enable}, 32'h0000_0000);
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, rtc_pkg::IDX_CTRL + 8'(i), 8'h00, 1'b1);
      check(rd, {24'h00_0000, exp[i]});
    end
  endtask
  task automatic t_access;
    bus(1'b1, rtc_pkg::IDX_SCRATCH, 8'ha5, 1'b1);
    bus(1'b1, rtc_pkg::IDX_SCRATCH, 8'h5a, 1'b0); // lane off: ignored
    bus(1'b1, 8'h6b, 8'h77, 1'b1);                // unmapped: ignored
    bus(1'b0, rtc_pkg::IDX_SCRATCH, 8'h00, 1'b1);
    check(rd, 32'h0000_00a5);
    check({31'h0, osc_enable}, 32'h0000_0000);
    bus(1'b0, 8'h6b, 8'h00, 1'b1);
    check(rd, 32'h0000_0000);
    set_time(8'h2a, 24'hc3_b4a5);
    bus(1'b0, rtc_pkg::IDX_MIN_MID, 8'h00, 1'b1);
    check(rd, 32'h0000_00b4);
  endtask
  // carry through both lower minute bytes on a seconds wrap
  task automatic t_wrap;
    set_time(8'h3b, 24'h00_ffff);
    bus(1'b1, rtc_pkg::IDX_IRQ_MASK, 8'h00, 1'b1);
    bus(1'b1, rtc_pkg::IDX_CTRL, 8'h0d, 1'b1);
    count(TICK + 8);
    check(tally(), 32'h0100_0101);
    check({31'h0, osc_enable}, 32'h0000_0001);
    bus(1'b0, rtc_pkg::IDX_SEC, 8'h00, 1'b1);
    check(rd, 32'h0000_0000);
    bus(1'b0, rtc_pkg::IDX_MIN_MID, 8'h00, 1'b1);
    check(rd, 32'h0000_0000);
    bus(1'b0, rtc_pkg::IDX_MIN_HIGH, 8'h00, 1'b1);
    check(rd, 32'h0000_0001);
    bus(1'b1, rtc_pkg::IDX_CTRL, 8'h00, 1'b0 + 1'b1);
  endtask
  // each interval code, one tick after enable: {ctrl, sec, min, event}
  task automatic t_modes;
    logic [31:0] tab [8] = '{32'h0510_0001, 32'h0410_0001, 32'h0d3b_0301,
                             32'h0d3a_0000, 32'h153b_0101, 32'h153b_0200,
                             32'h1d3b_0701, 32'h1d3b_0b00};
    logic        ev;
    logic [31:0] want;
    for (int i = 0; i < 8; i++) begin
      ev = tab[i][0];
      set_time(tab[i][23:16], {16'h0000, tab[i][15:8]});
      bus(1'b1, rtc_pkg::IDX_CTRL, tab[i][31:24], 1'b1);
      count(TICK + 8);
      want = {7'h0, ev, 8'h00, 7'h0, ev & tab[i][24], 7'h0, ev};
      check(tally(), want);
      bus(1'b1, rtc_pkg::IDX_CTRL, 8'h00, 1'b1);
    end
  endtask
  // alarm stays inactive until the top minute byte is written
  task automatic t_alarm;
    set_time(8'h05, 24'h00_0010);
    bus(1'b1, rtc_pkg::IDX_IRQ_MASK, 8'h02, 1'b1);
    bus(1'b1, rtc_pkg::IDX_ASEC, 8'h06, 1'b1);
    bus(1'b1, rtc_pkg::IDX_AMIN_LOW, 8'h10, 1'b1);
    bus(1'b1, rtc_pkg::IDX_AMIN_MID, 8'h00, 1'b1);
    bus(1'b1, rtc_pkg::IDX_CTRL, 8'h06, 1'b1);
    count(3 * TICK);
    check({16'h0000, ac[7:0], wc[7:0]}, 32'h0000_0000);
    bus(1'b1, rtc_pkg::IDX_CTRL, 8'h00, 1'b1);
    bus(1'b1, rtc_pkg::IDX_AMIN_HIGH, 8'h00, 1'b1);
    set_time(8'h05, 24'h00_0010);
    bus(1'b1, rtc_pkg::IDX_CTRL, 8'h06, 1'b1);
    count(TICK + 8);
    check(tally(), 32'h0101_0101);
    bus(1'b0, rtc_pkg::IDX_ASEC, 8'h00, 1'b1);
    check(rd, 32'h0000_0006);
    // same match with wake off and both masks set: event only
    bus(1'b1, rtc_pkg::IDX_CTRL, 8'h00, 1'b1);
    bus(1'b1, rtc_pkg::IDX_IRQ_MASK, 8'h03, 1'b1);
    set_time(8'h05, 24'h00_0010);
    bus(1'b1, rtc_pkg::IDX_CTRL, 8'h04, 1'b1);
    count(TICK + 8);
    check(tally(), 32'h0101_0000);
    bus(1'b1, rtc_pkg::IDX_CTRL, 8'h00, 1'b1);
  endtask
  // reset held six cycles, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_access;
    t_wrap;
    t_modes;
    t_alarm;
    close_out;
  end
endmodule // tb_rtc_alarm_periodic_wake
`default_nettype wire
